// [rtl/psi_pkg.sv]
// Purpose: shared constants of the printer adapter status and interrupt block
// Assumes: 20 MHz ref_clk, 32-bit AXI4-Lite register bus
// Notes:   every offset, bit position and timing count lives here
package psi_pkg;

	// clock and timing, times in ns, cycles derived (least times round up)
	localparam int CLK_PERIOD_NS = 50;
	localparam int STROBE_NS     = 500;   // data strobe width to printer
	localparam int BUSY_HOLD_NS  = 1000;  // least busy time after a transfer
	localparam int CLEAR_NS      = 2500;  // line buffer clear pulse width
	localparam int STROBE_CYC    =
		(STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_HOLD_CYC =
		(BUSY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_CYC     =
		(CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_DATA    = 8'h00; // output transfer
	localparam logic [ADDR_W-1:0] REG_CMD     = 8'h04; // command strobes
	localparam logic [ADDR_W-1:0] REG_FLAGS   = 8'h08; // flag_input_read
	localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h0C; // global irq enable
	localparam logic [ADDR_W-1:0] REG_IRQ_STS = 8'h10; // sticky events
	localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h14; // write one to clear
	localparam logic [ADDR_W-1:0] REG_IRQ_EN  = 8'h18; // per-event enable

	// status byte layout
	localparam int FLAG_BUSY    = 0;
	localparam int FLAG_READY   = 1;
	localparam int FLAG_SELECT  = 6;
	localparam int FLAG_NOTBUSY = 7;

	// command register bits
	localparam int CMD_INIT     = 0;
	localparam int CMD_CLEAR    = 1;
	localparam int CMD_SELECT   = 2;
	localparam int CMD_DESELECT = 3;

	// control and interrupt layout
	localparam int CTRL_GIE     = 0;
	localparam int IRQ_W        = 2;
	localparam int IRQ_NOTBUSY  = 0;
	localparam int IRQ_DESEL    = 1;

	// reset values and bus answers
	localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
	localparam logic [7:0]  DATA_RESET  = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// [rtl/psi_reg_if.sv]
// Purpose: register access carrier between bus slave and adapter core
// Assumes: one write and one read at most per cycle
// Notes:   hit flags are decoded by the core, combinational
`timescale 1ns/1ps
interface psi_reg_if;
	import psi_pkg::*;
	logic              wrEn;   // one-cycle write, low byte lane valid
	logic [ADDR_W-1:0] wrAddr; // write address
	logic [31:0]       wrData; // write data
	logic              wrHit;  // write address is mapped
	logic [ADDR_W-1:0] rdAddr; // read address
	logic [31:0]       rdData; // read data for rdAddr
	logic              rdHit;  // read address is mapped

	modport slave (output wrEn, wrAddr, wrData, rdAddr,
		input wrHit, rdData, rdHit);
	modport core (input wrEn, wrAddr, wrData, rdAddr,
		output wrHit, rdData, rdHit);
endinterface

// [rtl/psi_pulse_timer.sv]
// Purpose: retriggerable pulse of a fixed number of cycles
// Assumes: start and cancel never conflict; cancel wins if they do
// Notes:   active rises the cycle after start and lasts CYCLES cycles
`timescale 1ns/1ps
module psi_pulse_timer #(
	parameter int CYCLES = 10
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic cancel,
	output logic      active
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	logic [CW-1:0] count;  // cycles left in the pulse

	// load on start, run down to zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (cancel) begin
			count <= '0;
		end else if (start) begin
			count <= LOAD;
		end else if (count != '0) begin
			count <= count - CW'(1);
		end
	end

	assign active = (count != '0);
endmodule

// [rtl/psi_axil_slave.sv]
// Purpose: AXI4-Lite slave front end for the adapter registers
// Assumes: address and data may arrive in either order
// Notes:   one write and one read outstanding; unmapped gives SLVERR
`timescale 1ns/1ps
module psi_axil_slave
	import psi_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	psi_reg_if.slave           regs
);
	logic              awHave;  // address captured
	logic              wHave;   // data captured
	logic [ADDR_W-1:0] awAddr;  // held write address
	logic [31:0]       wData;   // held write data
	logic              wLow;    // low byte lane enabled
	logic              doWrite; // both halves present

	assign s_axi_awready = !awHave && !s_axi_bvalid;
	assign s_axi_wready  = !wHave && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign doWrite       = awHave && wHave && !s_axi_bvalid;

	// a write without the low lane is answered but changes nothing
	assign regs.wrEn   = doWrite && wLow;
	assign regs.wrAddr = awAddr;
	assign regs.wrData = wData;
	assign regs.rdAddr = s_axi_araddr;

	// capture write address and data, in either order
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			awHave <= 1'b0;
			wHave  <= 1'b0;
			awAddr <= '0;
			wData  <= ZERO_WORD;
			wLow   <= 1'b0;
		end else if (doWrite) begin
			awHave <= 1'b0;
			wHave  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave <= 1'b1;
				wData <= s_axi_wdata;
				wLow  <= s_axi_wstrb[0];
			end
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= regs.wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read data registered at the edge that takes the address
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= ZERO_WORD;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= regs.rdData;
			s_axi_rresp  <= regs.rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// [rtl/psi_top.sv]
// Purpose: printer adapter core: status flags, commands, interrupt
// Assumes: printer pins synchronous to ref_clk; prnAck is a pulse
// Notes:   registers reached over AXI4-Lite through psi_axil_slave
//
// Overview of operation
// - busy flag bit 0 falls after hold
// - device clear empties printer line buffer
// - initialise also empties printer line buffer
// - deselect command deselects, shown in bit 6
// - select command selects, shown in bit 6
// - deselect during transfer drops not-busy bit 7
// - interrupt when not-busy, admitted and enabled
// - no interrupt when not-busy low or disabled; an enabled deselect event still raises irq with not-busy low
// - transfer clears not-busy; acceptance sets it
// - initialise or device clear sets not-busy
// - status bit 1 shows printer ready
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module psi_top
	import psi_pkg::*;
#(
	parameter int STROBE_CYCLES = STROBE_CYC,    // strobe width
	parameter int BUSY_CYCLES   = BUSY_HOLD_CYC, // least busy time
	parameter int CLEAR_CYCLES  = CLEAR_CYC      // buffer clear pulse
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [7:0]             prnData,
	output logic                   prnStrobe,
	output logic                   prnClearBuf,
	output logic                   prnSelectReq,
	input  wire logic              prnBusy,
	input  wire logic              prnReady,
	input  wire logic              prnSelected,
	input  wire logic              prnAck,
	output logic                   irq
);
	// transfer sequencer states, one-hot
	typedef enum logic [2:0] {
		XF_IDLE   = 3'b001, // no transfer under way
		XF_STROBE = 3'b010, // strobe driven to the printer
		XF_WAIT   = 3'b100  // waiting for the printer to accept
	} psi_xfer_e;

	psi_reg_if regs ();

	psi_xfer_e      xferState;  // sequencer state
	psi_xfer_e      next_xferState;
	logic           notBusy;    // not-busy flag, status bit 7
	logic           gie;        // global interrupt enable
	logic [IRQ_W-1:0] irqSts;   // sticky interrupt events
	logic [IRQ_W-1:0] irqEn;    // per-event enables
	logic [IRQ_W-1:0] irqEvt;   // events raised this cycle
	logic [IRQ_W-1:0] irqClr;   // clear requests this cycle
	logic [IRQ_W-1:0] irqGate;  // level conditions per event
	logic [7:0]     flagByte;   // status byte for flag_input_read
	logic           busyHold;   // adapter busy hold running
	logic           strobeOn;   // strobe timer running
	logic           wrData;     // output transfer write
	logic           wrCmd;      // command register write
	logic           dataStart;  // transfer accepted
	logic           cmdInit;    // initialise command
	logic           cmdClear;   // device_clear_command
	logic           cmdSelect;  // select command
	logic           cmdDesel;   // deselect command
	logic           bufReset;   // either buffer-emptying command
	logic           ackEvt;     // printer accepted the character
	logic           inXfer;     // a transfer is under way

	// bus front end
	psi_axil_slave u_slave (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.regs          (regs.slave)
	);

	// write decode; commands act only on the low byte lane
	assign wrData    = regs.wrEn && (regs.wrAddr == REG_DATA);
	assign wrCmd     = regs.wrEn && (regs.wrAddr == REG_CMD);
	assign cmdInit   = wrCmd && regs.wrData[CMD_INIT];
	assign cmdClear  = wrCmd && regs.wrData[CMD_CLEAR];
	assign cmdSelect = wrCmd && regs.wrData[CMD_SELECT];
	assign cmdDesel  = wrCmd && regs.wrData[CMD_DESELECT];
	assign bufReset  = cmdInit || cmdClear;
	assign inXfer    = (xferState != XF_IDLE);
	// a data write during a transfer is ignored, never queued
	assign dataStart = wrData && !inXfer && !bufReset;
	assign ackEvt    = (xferState == XF_WAIT) && prnAck;

	// mapped addresses
	always_comb begin
		unique case (regs.wrAddr)
			REG_DATA, REG_CMD, REG_FLAGS, REG_CTRL,
			REG_IRQ_STS, REG_IRQ_CLR, REG_IRQ_EN: regs.wrHit = 1'b1;
			default: regs.wrHit = 1'b0;
		endcase
	end

	// strobe width to the printer
	psi_pulse_timer #(.CYCLES(STROBE_CYCLES)) u_strobe (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (dataStart),
		.cancel  (bufReset || cmdDesel),
		.active  (strobeOn)
	);

	// adapter busy hold; busy ends after it unless printer stays busy
	psi_pulse_timer #(.CYCLES(BUSY_CYCLES)) u_busy (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (dataStart),
		.cancel  (bufReset),
		.active  (busyHold)
	);

	// line buffer clear pulse toward the printer
	psi_pulse_timer #(.CYCLES(CLEAR_CYCLES)) u_clear (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (bufReset),
		.cancel  (1'b0),
		.active  (prnClearBuf)
	);

	// sequencer next state; buffer clear and deselect abort a transfer
	always_comb begin
		next_xferState = xferState;
		unique case (xferState)
			XF_IDLE: begin
				if (dataStart) begin
					next_xferState = XF_STROBE;
				end
			end
			XF_STROBE: begin
				// strobe timer already runs in the cycle of entry
				if (!strobeOn) begin
					next_xferState = XF_WAIT;
				end
			end
			XF_WAIT: begin
				if (prnAck) begin
					next_xferState = XF_IDLE;
				end
			end
			default: next_xferState = XF_IDLE;
		endcase
		if (bufReset || cmdDesel) begin
			next_xferState = XF_IDLE;
		end
	end

	// sequencer state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			xferState <= XF_IDLE;
		end else begin
			xferState <= next_xferState;
		end
	end

	// strobe comes straight from the state flop, glitch free
	assign prnStrobe = xferState[1];

	// character latched at transfer start, held for the printer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prnData <= DATA_RESET;
		end else if (dataStart) begin
			prnData <= regs.wrData[7:0];
		end
	end

	// not-busy flag; setting wins over a same-cycle clearing
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			notBusy <= 1'b1;
		end else if (bufReset) begin
			notBusy <= 1'b1;
		end else if (ackEvt) begin
			notBusy <= 1'b1;
		end else if (dataStart) begin
			notBusy <= 1'b0;
		end else if (cmdDesel && inXfer) begin
			notBusy <= 1'b0;
		end
	end

	// select request level toward the printer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prnSelectReq <= 1'b0;
		end else if (cmdDesel) begin
			prnSelectReq <= 1'b0;
		end else if (cmdSelect) begin
			prnSelectReq <= 1'b1;
		end
	end

	// status byte; the printer's own select answer is what is shown
	always_comb begin
		flagByte               = 8'h00;
		flagByte[FLAG_BUSY]    = busyHold || prnBusy;
		flagByte[FLAG_READY]   = prnReady;
		flagByte[FLAG_SELECT]  = prnSelected;
		flagByte[FLAG_NOTBUSY] = notBusy;
	end

	// global enable and per-event enables
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gie   <= 1'b0;
			irqEn <= '0;
		end else if (regs.wrEn) begin
			if (regs.wrAddr == REG_CTRL) begin
				gie <= regs.wrData[CTRL_GIE];
			end
			if (regs.wrAddr == REG_IRQ_EN) begin
				irqEn <= regs.wrData[IRQ_W-1:0];
			end
		end
	end

	// events: not-busy rising, and a deselect command
	always_comb begin
		irqEvt              = '0;
		irqEvt[IRQ_NOTBUSY] = !notBusy && (bufReset || ackEvt);
		irqEvt[IRQ_DESEL]   = cmdDesel;
		irqClr              = '0;
		if (regs.wrEn && (regs.wrAddr == REG_IRQ_CLR)) begin
			irqClr = regs.wrData[IRQ_W-1:0];
		end
		// not-busy event only counts while the flag is still high
		irqGate              = '1;
		irqGate[IRQ_NOTBUSY] = notBusy;
	end

	// sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irqSts <= '0;
		end else begin
			irqSts <= (irqSts & ~irqClr) | irqEvt;
		end
	end

	// level interrupt: enabled, admitted, and condition still true
	assign irq = gie && |(irqSts & irqEn & irqGate);

	// read mux; write-only clear register and unused bits read zero
	always_comb begin
		regs.rdData = ZERO_WORD;
		regs.rdHit  = 1'b1;
		unique case (regs.rdAddr)
			REG_DATA:    regs.rdData[7:0] = prnData;
			REG_CMD:     regs.rdData[CMD_SELECT] = prnSelectReq;
			REG_FLAGS:   regs.rdData[7:0] = flagByte;
			REG_CTRL:    regs.rdData[CTRL_GIE] = gie;
			REG_IRQ_STS: regs.rdData[IRQ_W-1:0] = irqSts;
			REG_IRQ_CLR: regs.rdData = ZERO_WORD;
			REG_IRQ_EN:  regs.rdData[IRQ_W-1:0] = irqEn;
			default:     regs.rdHit = 1'b0;
		endcase
	end
endmodule

// [dv/psi_top_sva.sv]
// Purpose: port-level checks of the printer adapter core
// Assumes: bound to psi_top, one clock domain
// Notes:   pulse widths are kept in small counters
`timescale 1ns/1ps
module psi_top_sva
	import psi_pkg::*;
#(
	parameter int STROBE_CYCLES = STROBE_CYC, // strobe width
	parameter int CLEAR_CYCLES  = CLEAR_CYC   // clear pulse width
) (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [7:0]  prnData,
	input wire logic        prnStrobe,
	input wire logic        prnClearBuf
);
	int strCnt; // cycles the strobe has stood high
	int clrCnt; // cycles the clear pulse has stood high

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// strobe width, restarted whenever the strobe drops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			strCnt <= 0;
		else
			strCnt <= prnStrobe ? strCnt + 1 : 0;
	end

	// clear pulse width, read back at its falling edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			clrCnt <= 0;
		else
			clrCnt <= prnClearBuf ? clrCnt + 1 : 0;
	end

	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer late or early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer missing");
	a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_refused: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_char_steady: assert property (prnStrobe && $past(prnStrobe)
		|-> $stable(prnData))
		else $error("character changed under strobe");
	a_strobe_width: assert property (strCnt <= STROBE_CYCLES + 1)
		else $error("strobe too long");
	a_clear_width: assert property ($fell(prnClearBuf)
		|-> clrCnt == CLEAR_CYCLES)
		else $error("clear pulse has wrong width");
endmodule

bind psi_top psi_top_sva #(
	.STROBE_CYCLES(STROBE_CYCLES),
	.CLEAR_CYCLES(CLEAR_CYCLES)
) u_psi_top_sva (
	.ref_clk(ref_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.prnData(prnData), .prnStrobe(prnStrobe), .prnClearBuf(prnClearBuf)
);

// [dv/psi_printer_model.sv]
// Purpose: behavioural line printer on the far side of the adapter
// Assumes: printer pins synchronous to ref_clk
// Notes:   slow stretches the acceptance time eightfold
`timescale 1ns/1ps
module psi_printer_model
	import psi_pkg::*;
#(
	parameter int ACK_DELAY = 4 // cycles from strobe end to acceptance
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [7:0] prnData,
	input  wire logic       prnStrobe,
	input  wire logic       prnClearBuf,
	input  wire logic       prnSelectReq,
	input  wire logic       online,
	input  wire logic       slow,
	output logic            prnBusy,
	output logic            prnReady,
	output logic            prnSelected,
	output logic            prnAck,
	output logic [7:0]      lastChar,
	output int              bufCount,
	output int              lineNo
);
	logic strobeQ; // strobe a cycle late, for edge finding
	int   waitCnt; // cycles left until acceptance

	// select and ready answer a cycle after request and switch
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prnSelected <= 1'b0;
			prnReady    <= 1'b0;
		end else begin
			prnSelected <= prnSelectReq;
			prnReady    <= online;
		end
	end

	// intake, acceptance and the line buffer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			strobeQ  <= 1'b0;
			prnBusy  <= 1'b0;
			prnAck   <= 1'b0;
			lastChar <= 8'h00;
			bufCount <= 0;
			lineNo   <= 0;
			waitCnt  <= 0;
		end else begin
			strobeQ <= prnStrobe;
			prnAck  <= 1'b0;
			if (prnClearBuf) begin
				// pending line and acceptance are both dropped
				bufCount <= 0;
				prnBusy  <= 1'b0;
				waitCnt  <= 0;
			end else if (prnStrobe && !strobeQ) begin
				prnBusy  <= 1'b1;
				lastChar <= prnData;
				case (prnData)
					8'h0C: lineNo <= 0;   // top of next form
					8'h0D: bufCount <= 0; // line printed
					8'h0B: lineNo <= 6;   // sixth line
					default: if (prnData >= 8'h20 && prnData <= 8'h5F) begin
						bufCount <= bufCount + 1;
					end
				endcase
			end else if (!prnStrobe && strobeQ) begin
				waitCnt <= slow ? 8 * ACK_DELAY : ACK_DELAY;
			end else if (waitCnt == 1) begin
				prnAck  <= 1'b1;
				prnBusy <= 1'b0;
				waitCnt <= 0;
			end else if (waitCnt > 1) begin
				waitCnt <= waitCnt - 1;
			end
		end
	end
endmodule

// [dv/printer_adapter_status_irq_tb.sv]
// Purpose: self-checking bench of the printer adapter core
// Assumes: bready and rready held high, so answers last one cycle
// Notes:   short timer values keep the run brief
`timescale 1ns/1ps
module printer_adapter_status_irq_tb;
	import psi_pkg::*;
	typedef struct {
		logic              wr;   // write when set
		logic [ADDR_W-1:0] addr; // byte address
		logic [31:0]       data; // write data or expected read data
		logic [1:0]        resp; // expected response
	} psi_row_s;

	logic ref_clk = 1'b0, rst = 1'b1, online = 1'b1, slow = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, prnStrobe, prnClearBuf, prnSelectReq, irq;
	logic prnBusy, prnReady, prnSelected, prnAck;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0] prnData, lastChar;
	int bufCount, lineNo, fails = 0, num_checks = 0, cycles = 0;
	psi_row_s rows [12] = '{
		'{1'b0, REG_FLAGS, 32'h0000_0082, RESP_OKAY},
		'{1'b0, REG_IRQ_STS, 32'h0000_0000, RESP_OKAY},
		'{1'b1, REG_CTRL, 32'h0000_0001, RESP_OKAY},
		'{1'b0, REG_CTRL, 32'h0000_0001, RESP_OKAY},
		'{1'b1, REG_IRQ_EN, 32'h0000_0003, RESP_OKAY},
		'{1'b0, REG_IRQ_EN, 32'h0000_0003, RESP_OKAY},
		'{1'b1, REG_IRQ_CLR, 32'h0000_0003, RESP_OKAY},
		'{1'b0, REG_IRQ_CLR, 32'h0000_0000, RESP_OKAY},
		'{1'b1, REG_FLAGS, 32'h0000_00FF, RESP_OKAY},
		'{1'b0, REG_FLAGS, 32'h0000_0082, RESP_OKAY},
		'{1'b1, 8'h1C, 32'h0000_0001, RESP_SLVERR},
		'{1'b0, 8'h1C, 32'h0000_0000, RESP_SLVERR}};

	psi_top #(.STROBE_CYCLES(2), .BUSY_CYCLES(3), .CLEAR_CYCLES(3))
		u_psi_top (.*);
	psi_printer_model u_psi_printer_model (.*);

	always #25 ref_clk = ~ref_clk; // 20 MHz

	// compare after outputs have settled
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t ns: %s", $time, what);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic axi_write(input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		logic ta, tw, tb;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		do begin
			#1;
			ta  = s_axi_awvalid && s_axi_awready;
			tw  = s_axi_wvalid && s_axi_wready;
			tb  = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge ref_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
	endtask

	// data and response are taken at the edge that sees rvalid
	task automatic axi_read(input logic [ADDR_W-1:0] a);
		logic ta, tr;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			#1;
			ta  = s_axi_arvalid && s_axi_arready;
			tr  = s_axi_rvalid;
			rd  = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge ref_clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tr);
	endtask

	// poll the flags until the transfer is over, bounded
	task automatic wait_idle();
		int n = 0;
		do begin
			axi_read(REG_FLAGS);
			n++;
		end while (rd[FLAG_NOTBUSY] !== 1'b1 && n < 60);
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// hang guard; the normal run needs far fewer cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			print_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		foreach (rows[i]) begin
			if (rows[i].wr) axi_write(rows[i].addr, rows[i].data);
			else axi_read(rows[i].addr);
			check(rsp, rows[i].resp, "response");
			if (!rows[i].wr && rows[i].resp === RESP_OKAY)
				check(rd, rows[i].data, "read data");
		end
		$display("test register rows done");
		// transfer, busy and not-busy, interrupt gating
		axi_write(REG_IRQ_EN, 32'h0000_0001);
		axi_write(REG_DATA, 32'h0000_0041);
		axi_read(REG_FLAGS);
		check(rd, 32'h0000_0003, "flags mid transfer");
		wait_idle();
		check(rd, 32'h0000_0082, "flags after transfer");
		check(irq, 1'b1, "irq when idle");
		check(lastChar, 8'h41, "character");
		axi_write(REG_CTRL, 32'h0000_0000);
		check(irq, 1'b0, "irq disabled");
		axi_write(REG_CTRL, 32'h0000_0001);
		slow <= 1'b1;
		axi_write(REG_DATA, 32'h0000_0042);
		check(irq, 1'b0, "irq while busy");
		wait_idle();
		check(irq, 1'b1, "irq after slow ack");
		axi_write(REG_IRQ_CLR, 32'h0000_0001);
		check(irq, 1'b0, "irq cleared");
		slow <= 1'b0;
		$display("test transfer and interrupt done");
		// initialise and device clear in mid transfer
		for (int c = CMD_INIT; c <= CMD_CLEAR; c++) begin
			axi_write(REG_DATA, 32'h0000_0045);
			axi_write(REG_CMD, 32'h0000_0001 << c);
			axi_read(REG_FLAGS);
			check(rd & 32'h0000_0080, 32'h0000_0080, "not-busy");
			repeat (8) @(posedge ref_clk);
			check(bufCount, 0, "line buffer");
		end
		$display("test clear commands done");
		// select, then deselect in mid transfer
		axi_write(REG_CMD, 32'h0000_0004);
		axi_read(REG_CMD);
		check(rd, 32'h0000_0004, "select request");
		axi_read(REG_FLAGS);
		check(rd, 32'h0000_00C2, "selected");
		axi_write(REG_DATA, 32'h0000_000B);
		axi_write(REG_CMD, 32'h0000_0008);
		repeat (8) @(posedge ref_clk);
		axi_read(REG_FLAGS);
		check(rd & 32'h0000_00C0, 32'h0000_0000, "deselected");
		check(lineNo, 6, "vertical tab");
		axi_read(REG_IRQ_STS);
		check(rd & 32'h0000_0002, 32'h0000_0002, "deselect event");
		axi_write(REG_CMD, 32'h0000_0001);
		online <= 1'b0;
		repeat (8) @(posedge ref_clk);
		axi_read(REG_FLAGS);
		check(rd, 32'h0000_0080, "printer not ready");
		online <= 1'b1;
		$display("test select and ready done");
		// second reset in mid run
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		axi_read(REG_CTRL);
		check(rd, 32'h0000_0000, "control after reset");
		axi_read(REG_FLAGS);
		check(rd, 32'h0000_0082, "flags after reset");
		check(irq, 1'b0, "irq after reset");
		$display("test second reset done");
		print_verdict();
	end
endmodule
